// ### logic/phy_event_irq_pkg.sv
// constants shared by the physical-layer event interrupt group
package phy_event_irq_pkg;

    // bus widths
    localparam int unsigned ADDR_W_DEF   = 8;
    localparam int unsigned DATA_W       = 8;

    // register addresses
    localparam logic [7:0]  ENABLE_ADDR  = 8'h7D;
    localparam logic [7:0]  PEEK_ADDR    = 8'h7E;
    localparam logic [7:0]  CLEAR_ADDR   = 8'h7F;

    // bit positions shared by flags and enables
    localparam int unsigned WAKE_POS     = 5;
    localparam int unsigned LINK_POS     = 4;
    localparam int unsigned JABBER_POS   = 3;
    localparam int unsigned FAIL_POS     = 2;
    localparam int unsigned RSVD_POS     = 1;
    localparam int unsigned DONE_POS     = 0;

    // implemented bits and reset values
    localparam logic [7:0]  FLAG_MASK    = 8'h3D;
    localparam logic [7:0]  ENABLE_RESET = 8'h00;
    localparam logic [7:0]  FLAG_RESET   = 8'h00;
    localparam logic [7:0]  READ_IDLE    = 8'h00;

endpackage : phy_event_irq_pkg

// ### logic/phy_event_irq_status_enable.sv
// physical-layer event flags, enable register and interrupt request
//
// How it works
// R1 - reading the peek register returns the flags and clears none of them
// R2 - peek bit 5 shows the wake flag, set by a network connection
// R3 - peek bit 4 shows the link-change flag, set on cable connect or remove
// R4 - peek bit 3 shows the jabber flag, set when jabber is detected
// R5 - peek bit 2 shows the negotiation-fail flag
// R6 - peek bit 0 shows the negotiation-done flag
// R7 - peek bit 1 always reads zero
// R8 - enable bit 4 lets the link-change flag raise the interrupt
// R9 - enable bit 3 lets the jabber flag raise the interrupt
// R10 - enable bit 2 lets the negotiation-fail flag raise the interrupt
// R11 - enable bit 0 lets the negotiation-done flag raise the interrupt
// R12 - enable bit 5 lets the wake flag raise the interrupt
// R13 - host writes zero to enable bit 1; it always reads zero
// R14 - reading the clearing register clears every flag of the group
// R15 - bits 7 and 6 of both registers read zero, writes ignored
// R16 - interrupt is high while any flag is set with its enable bit
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module phy_event_irq_status_enable #(
    parameter int unsigned ADDR_W = phy_event_irq_pkg::ADDR_W_DEF
) (
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              srst_i,
    // register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wr_data_i,
    input  wire logic              wr_stb_i,
    input  wire logic              rd_stb_i,
    output logic [7:0]             rd_data_o,
    // physical-layer events, same clock
    input  wire logic              wake_event_i,
    input  wire logic              link_change_event_i,
    input  wire logic              jabber_event_i,
    input  wire logic              negotiation_fail_event_i,
    input  wire logic              negotiation_done_event_i,
    // interrupt request
    output logic                   irq_o
);

    // refuse an address too narrow for the register map
    if (ADDR_W < 7) begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    // decoded accesses
    logic        en_wr;
    logic        peek_rd;
    logic        clear_rd;
    logic        clear_wr;
    logic [7:0]  sel_data;

    // register state
    logic [7:0]  en_q;
    logic [7:0]  en_d;
    logic [7:0]  flags;
    logic [7:0]  events;
    logic [7:0]  clr_bits;
    logic        irq_q;
    logic        irq_d;

    // addresses at the port width
    localparam logic [ADDR_W-1:0] A_EN =
        ADDR_W'(phy_event_irq_pkg::ENABLE_ADDR);
    localparam logic [ADDR_W-1:0] A_PEEK =
        ADDR_W'(phy_event_irq_pkg::PEEK_ADDR);
    localparam logic [ADDR_W-1:0] A_CLR =
        ADDR_W'(phy_event_irq_pkg::CLEAR_ADDR);

    // write decode
    always_comb begin
        en_wr    = 1'b0;
        clear_wr = 1'b0;
        if (wr_stb_i && addr_i == A_EN) begin
            en_wr = 1'b1;
        end else if (wr_stb_i && addr_i == A_CLR) begin
            clear_wr = 1'b1;
        end
    end

    // read decode
    always_comb begin
        peek_rd  = 1'b0;
        clear_rd = 1'b0;
        if (rd_stb_i && addr_i == A_PEEK) begin
            peek_rd = 1'b1;
        end else if (rd_stb_i && addr_i == A_CLR) begin
            clear_rd = 1'b1;
        end
    end

    // read data select; unmapped addresses answer zero
    always_comb begin
        sel_data = phy_event_irq_pkg::READ_IDLE;
        if (rd_stb_i && addr_i == A_EN) begin
            sel_data = en_q & phy_event_irq_pkg::FLAG_MASK;
        end else if (peek_rd) begin
            // R1 peek returns flags
            sel_data = flags & phy_event_irq_pkg::FLAG_MASK;
        end else if (clear_rd) begin
            sel_data = flags & phy_event_irq_pkg::FLAG_MASK;
        end
    end

    // registered read answer
    read_port #(
        .W          (phy_event_irq_pkg::DATA_W)
    ) u_read_port (
        .sys_clk_i  (sys_clk_i),
        .srst_i     (srst_i),
        .rd_stb_i   (rd_stb_i),
        .sel_data_i (sel_data),
        .rd_data_o  (rd_data_o)
    );

    // gather event inputs into the flag layout
    always_comb begin
        events = 8'h00;
        // R2 wake sets bit
        events[phy_event_irq_pkg::WAKE_POS]   = wake_event_i;
        // R3 link change sets bit
        events[phy_event_irq_pkg::LINK_POS]   = link_change_event_i;
        // R4 jabber sets bit
        events[phy_event_irq_pkg::JABBER_POS] = jabber_event_i;
        // R5 negotiation fail sets bit
        events[phy_event_irq_pkg::FAIL_POS]   = negotiation_fail_event_i;
        // R6 negotiation done sets bit
        events[phy_event_irq_pkg::DONE_POS]   = negotiation_done_event_i;
    end

    // clearing: destructive read clears all, write-one clears chosen bits
    always_comb begin
        clr_bits = 8'h00;
        if (clear_rd) begin
            // R14 destructive read clears
            clr_bits = phy_event_irq_pkg::FLAG_MASK;
        end else if (clear_wr) begin
            clr_bits = wr_data_i & phy_event_irq_pkg::FLAG_MASK;
        end
    end

    // one sticky cell per implemented bit; the rest stay zero
    for (genvar i = 0; i < 8; i++) begin : g_flag
        if (phy_event_irq_pkg::FLAG_MASK[i]) begin : g_cell
            sticky_flag u_flag (
                .sys_clk_i (sys_clk_i),
                .srst_i    (srst_i),
                .set_i     (events[i]),
                .clr_i     (clr_bits[i]),
                .flag_o    (flags[i])
            );
        end else begin : g_zero
            // R7 reserved flag zero
            assign flags[i] = 1'b0;
        end
    end

    // enable next value: only implemented bits are stored
    always_comb begin
        en_d = en_q;
        if (en_wr) begin
            // R13 bit 1 never stored
            // R15 upper bits dropped
            en_d = wr_data_i & phy_event_irq_pkg::FLAG_MASK;
        end
    end

    // enable register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            en_q <= phy_event_irq_pkg::ENABLE_RESET;
        end else begin
            // R8 link enable stored
            // R9 jabber enable stored
            // R10 fail enable stored
            // R11 done enable stored
            // R12 wake enable stored
            en_q <= en_d;
        end
    end

    // interrupt request from flags gated by enables
    always_comb begin
        // R16 gated flag request
        irq_d = |(flags & en_q & phy_event_irq_pkg::FLAG_MASK);
    end

    // registered interrupt output
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irq_o = irq_q;

    // ------------------------------------------------------------------
    // checks on the driven behaviour
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    // peek read strobe
    sequence s_peek_rd;
        rd_stb_i && addr_i == A_PEEK;
    endsequence

    // destructive read strobe with no event in the same cycle
    sequence s_clear_quiet;
        rd_stb_i && addr_i == A_CLR && events == 8'h00;
    endsequence

    // enable write strobe
    sequence s_en_wr;
        wr_stb_i && addr_i == A_EN;
    endsequence

    // enable read strobe
    sequence s_en_rd;
        rd_stb_i && addr_i == A_EN;
    endsequence

    // write strobe on the clearing register
    sequence s_clear_wr;
        wr_stb_i && addr_i == A_CLR;
    endsequence

    // peek answer equals flags, and no flag dropped by the peek
    a_peek_keeps_flags: assert property ( // R1
        s_peek_rd |=> rd_data_o == ($past(flags) & 8'h3D)
            && ((flags & $past(flags)) == $past(flags)))
        else $error("peek read changed or misreported flags");

    // wake event sets bit 5
    a_wake_flag_set: assert property ( // R2
        wake_event_i |=> flags[5])
        else $error("wake event not recorded in bit 5");

    // peek of a set wake flag shows bit 5
    a_wake_peek: assert property ( // R2
        s_peek_rd ##0 flags[5] |=> rd_data_o[5])
        else $error("wake flag missing from peek answer");

    // link change sets bit 4
    a_link_flag_set: assert property ( // R3
        link_change_event_i |=> flags[4])
        else $error("link change not recorded in bit 4");

    // jabber sets bit 3
    a_jabber_flag_set: assert property ( // R4
        jabber_event_i |=> flags[3])
        else $error("jabber not recorded in bit 3");

    // negotiation fail sets bit 2
    a_fail_flag_set: assert property ( // R5
        negotiation_fail_event_i |=> flags[2])
        else $error("negotiation fail not recorded in bit 2");

    // negotiation done sets bit 0
    a_done_flag_set: assert property ( // R6
        negotiation_done_event_i |=> flags[0])
        else $error("negotiation done not recorded in bit 0");

    // reserved and unused bits of every answer read zero
    a_rsvd_bits_zero: assert property ( // R7
        rd_data_o[7:6] == 2'b00 && rd_data_o[1] == 1'b0)
        else $error("reserved read bit not zero");

    // enable write stores implemented bits
    a_enable_write: assert property ( // R8
        s_en_wr |=> en_q == ($past(wr_data_i) & phy_event_irq_pkg::FLAG_MASK))
        else $error("enable register stored wrong");

    // enable read answers the stored bits
    a_enable_readback: assert property ( // R11
        s_en_rd |=> rd_data_o == $past(en_q))
        else $error("enable register read back wrong");

    // enable bit 1 and upper bits never stored
    a_enable_rsvd: assert property ( // R15
        en_q[7:6] == 2'b00 && en_q[1] == 1'b0)
        else $error("reserved enable bit stored");

    // quiet destructive read leaves every flag clear
    a_clear_read: assert property ( // R14
        s_clear_quiet |=> flags == 8'h00)
        else $error("destructive read did not clear flags");

    // peek after a quiet destructive read answers zero
    a_clear_peek: assert property ( // R14
        s_clear_quiet ##1 (events == 8'h00) ##1 s_peek_rd
            |=> rd_data_o == 8'h00)
        else $error("peek after clearing read not zero");

    // event during a destructive read survives
    a_set_wins: assert property ( // R14
        rd_stb_i && addr_i == A_CLR && link_change_event_i |=> flags[4])
        else $error("event lost during clearing read");

    // interrupt follows gated flags one cycle later
    a_irq_level: assert property ( // R16
        irq_o == $past(|(flags & en_q)))
        else $error("interrupt level wrong");

    // with no enabled flag set, no interrupt in the next cycle
    a_jabber_gated: assert property ( // R9
        (flags & en_q) == 8'h00 |=> !irq_o)
        else $error("interrupt without enabled flag");

    // enabled wake flag raises interrupt within two cycles
    a_wake_irq: assert property ( // R12
        wake_event_i && en_q[5] && !en_wr |-> ##[1:2] irq_o)
        else $error("enabled wake did not interrupt");

    // enabled link-change flag raises the interrupt
    a_link_irq: assert property ( // R8
        flags[4] && en_q[4] |=> irq_o)
        else $error("enabled link change did not interrupt");

    // enabled jabber flag raises the interrupt
    a_jabber_irq: assert property ( // R9
        flags[3] && en_q[3] |=> irq_o)
        else $error("enabled jabber did not interrupt");

    // enabled negotiation-fail flag raises the interrupt
    a_fail_irq: assert property ( // R10
        flags[2] && en_q[2] |=> irq_o)
        else $error("enabled negotiation fail did not interrupt");

    // enabled negotiation-done flag raises the interrupt
    a_done_irq: assert property ( // R11
        flags[0] && en_q[0] |=> irq_o)
        else $error("enabled negotiation done did not interrupt");

    // write-one clear drops the chosen flags when no event collides
    a_write_clear: assert property ( // R14
        s_clear_wr ##0 ((wr_data_i & events) == 8'h00)
            |=> (flags & $past(wr_data_i)) == 8'h00)
        else $error("write clear left a chosen flag set");

    // with no read strobe the answer returns to zero
    a_idle_read_zero: assert property ( // R1
        !rd_stb_i |=> rd_data_o == 8'h00)
        else $error("read answer did not return to zero");

endmodule // phy_event_irq_status_enable

`default_nettype wire

// ### logic/read_port.sv
// read data register, valid only in the cycle after a read strobe
`timescale 1ns/10ps
`default_nettype none

module read_port #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         srst_i,
    // selected data
    input  wire logic         rd_stb_i,
    input  wire logic [W-1:0] sel_data_i,
    // registered answer
    output logic [W-1:0]      rd_data_o
);

    logic [W-1:0] rd_data_q;

    // capture on a strobe, return to zero otherwise
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rd_data_q <= '0;
        end else if (rd_stb_i) begin
            rd_data_q <= sel_data_i;
        end else begin
            rd_data_q <= '0;
        end
    end

    assign rd_data_o = rd_data_q;

endmodule // read_port

`default_nettype wire

// ### logic/sticky_flag.sv
// one sticky event flag, set wins over clear
`timescale 1ns/10ps
`default_nettype none

module sticky_flag (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    // set and clear
    input  wire logic set_i,
    input  wire logic clr_i,
    // flag state
    output logic      flag_o
);

    logic flag_q;

    // an event in the clearing cycle keeps the flag set
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            flag_q <= 1'b0;
        end else if (set_i) begin
            flag_q <= 1'b1;
        end else if (clr_i) begin
            flag_q <= 1'b0;
        end
    end

    assign flag_o = flag_q;

endmodule // sticky_flag

`default_nettype wire

// ### testbench/phy_event_source.sv
// physical-layer event source facing the interrupt group
`timescale 1ns/10ps
`default_nettype none

module phy_event_source (
    // clock
    input  wire logic       sys_clk_i,
    // event request, one bit per flag position
    input  wire logic [7:0] req_i,
    // event outputs
    output logic            wake_o,
    output logic            link_o,
    output logic            jabber_o,
    output logic            fail_o,
    output logic            done_o
);
    // request bits 5, 4, 3, 2 and 0 become events a cycle later, lasting as long as the request; bits 7, 6 and 1 drive nothing
    always_ff @(posedge sys_clk_i) begin
        wake_o   <= req_i[5];
        link_o   <= req_i[4];
        jabber_o <= req_i[3];
        fail_o   <= req_i[2];
        done_o   <= req_i[0];
    end
endmodule // phy_event_source

`default_nettype wire

// ### testbench/tb_phy_event_irq_status_enable.sv
// self-checking bench for the physical-layer event interrupt group
`timescale 1ns/10ps
`default_nettype none

module tb_phy_event_irq_status_enable;
    localparam logic [7:0] EN = phy_event_irq_pkg::ENABLE_ADDR;
    localparam logic [7:0] PK = phy_event_irq_pkg::PEEK_ADDR;
    localparam logic [7:0] CL = phy_event_irq_pkg::CLEAR_ADDR;
    logic       sys_clk_i = 1'b0;
    logic       srst_i    = 1'b1;
    logic [7:0] addr_i    = 8'h00;
    logic [7:0] wr_data_i = 8'h00;
    logic       wr_stb_i  = 1'b0;
    logic       rd_stb_i  = 1'b0;
    logic [7:0] ev_req    = 8'h00;
    logic [7:0] rd_data_o;
    logic       irq_o;
    wire logic [4:0] ev;
    logic       rd_pend   = 1'b0;
    logic [7:0] exp_q[$];
    int         fails = 0;
    int         total_checks = 0;

    // clock, 40 ns period
    always #20 sys_clk_i = ~sys_clk_i;

    phy_event_source PEER (
        .sys_clk_i (sys_clk_i),
        .req_i     (ev_req),
        .wake_o    (ev[4]),
        .link_o    (ev[3]),
        .jabber_o  (ev[2]),
        .fail_o    (ev[1]),
        .done_o    (ev[0])
    );

    phy_event_irq_status_enable #(.ADDR_W(8)) DUT (
        .sys_clk_i                (sys_clk_i),
        .srst_i                   (srst_i),
        .addr_i                   (addr_i),
        .wr_data_i                (wr_data_i),
        .wr_stb_i                 (wr_stb_i),
        .rd_stb_i                 (rd_stb_i),
        .rd_data_o                (rd_data_o),
        .wake_event_i             (ev[4]),
        .link_change_event_i      (ev[3]),
        .jabber_event_i           (ev[2]),
        .negotiation_fail_event_i (ev[1]),
        .negotiation_done_event_i (ev[0]),
        .irq_o                    (irq_o)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_stb_i  <= 1'b1;
        @(posedge sys_clk_i);
        wr_stb_i  <= 1'b0;
    endtask

    // read request; the expected byte is noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr_i   <= a;
        rd_stb_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        rd_stb_i <= 1'b0;
    endtask

    // pulse events, then let flag and interrupt settle
    task automatic fire(input logic [7:0] m);
        @(posedge sys_clk_i);
        ev_req <= m;
        @(posedge sys_clk_i);
        ev_req <= 8'h00;
        repeat (3) @(posedge sys_clk_i);
    endtask

    task automatic irq_is(input logic e);
        check({7'h00, irq_o}, {7'h00, e});
    endtask

    // monitor: read data stand in the cycle after the strobe
    always @(posedge sys_clk_i) begin
        if (rd_pend) begin
            if (exp_q.size() == 0) check(rd_data_o, 8'hEE);
            else check(rd_data_o, exp_q.pop_front());
        end
        rd_pend = rd_stb_i;
    end

    // watchdog on the whole run
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fails++;
        summarize();
    end

    // main sequence
    initial begin : main
        logic [7:0] d;
        logic [7:0] m;
        int unsigned pos [5];
        pos = '{5, 4, 3, 2, 0};
        d = 8'($urandom(38199));
        repeat (12) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd(EN, 8'h00);
        rd(PK, 8'h00);
        irq_is(1'b0);
        $display("test reset values done");
        wr(EN, 8'hFD);
        rd(EN, 8'h3D);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom) & 8'hFD;
            wr(EN, d);
            rd(EN, d & 8'h3D);
        end
        wr(PK, 8'hFF);
        rd(PK, 8'h00);
        m = 8'($urandom);
        if (m >= 8'h7D && m <= 8'h7F) m = 8'h10;
        wr(m, 8'hFF);
        rd(m, 8'h00);
        rd(EN, d & 8'h3D);
        $display("test register access done");
        for (int i = 0; i < 5; i++) begin
            m = 8'h01 << pos[i];
            wr(EN, 8'h3D & ~m);
            fire(m);
            irq_is(1'b0);
            rd(PK, m);
            rd(PK, m);
            wr(EN, m);
            repeat (2) @(posedge sys_clk_i);
            irq_is(1'b1);
            rd(CL, m);
            rd(PK, 8'h00);
            repeat (2) @(posedge sys_clk_i);
            irq_is(1'b0);
        end
        $display("test each event done");
        // an event in the clearing read cycle survives the clear
        @(posedge sys_clk_i);
        ev_req <= 8'h10;
        rd(CL, 8'h00);
        ev_req <= 8'h00;
        rd(PK, 8'h10);
        // write-one clear drops only the chosen flags
        fire(8'h05);
        wr(CL, 8'h01);
        rd(PK, 8'h14);
        rd(CL, 8'h14);
        rd(PK, 8'h00);
        $display("test clearing races done");
        wr(EN, 8'h3D);
        fire(8'hFF);
        rd(PK, 8'h3D);
        repeat (2) @(posedge sys_clk_i);
        irq_is(1'b1);
        srst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd(PK, 8'h00);
        rd(EN, 8'h00);
        irq_is(1'b0);
        $display("test mid-run reset done");
        repeat (3) @(posedge sys_clk_i);
        summarize();
    end
endmodule // tb_phy_event_irq_status_enable

`default_nettype wire
